// *** hw/ata_passthru_decoder.sv ***
// Decoder and sequencer for the pass-through command block.
// Assumes one clock; only the drive error pin and the reset are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module ata_passthru_decoder (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Command block bytes
    input wire logic cb_valid_in,
    input wire logic [7:0] cb_byte_in,
    // Configuration
    input wire logic [7:0] vendor_cmd_signature_in,
    input wire logic [7:0] config_dev_byte_in,
    // Taskfile access port
    output logic tf_req_out,
    output logic tf_write_out,
    output logic tf_hob_out,
    output logic [2:0] tf_sel_out,
    output logic [7:0] tf_wdata_out,
    input wire logic tf_ack_in,
    input wire logic [7:0] tf_rdata_in,
    // Data phase
    output logic data_start_out,
    output logic ultra_dma_enable_out,
    output logic identify_data_flag_out,
    output logic data_halt_out,
    input wire logic data_done_in,
    input wire logic phase_error_in,
    input wire logic drive_error_pin_in,
    // Results
    output logic rd_valid_out,
    output logic [7:0] rd_byte_out,
    output logic other_cmd_out,
    output logic cmd_done_out,
    output logic busy_out
);
    import ata_passthru_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchroniser
    logic rst_s1_reg, rst_s2_reg, rst_n;
    logic drive_error;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    pin_sync3 u_drive_err_sync (
        .clk_in(clk_in),
        .reset_n_in(rst_n),
        .d_in(drive_error_pin_in),
        .q_out(drive_error)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Return offset of a read
    function automatic logic [3:0] ret_off(input logic [2:0] idx, input logic hob);
        logic [3:0] off;
        off = RET_STAT;
        if (idx == TF_ALT) begin
            off = RET_ALT;
        end else if (idx == TF_FEAT) begin
            off = RET_ERR;
        end else if (idx == TF_DEVHEAD) begin
            off = RET_DEV;
        end else if (idx != TF_CMD) begin
            off = (hob ? RET_HOB_BASE : RET_LOB_BASE) + {1'b0, idx} - {1'b0, TF_COUNT};
        end
        return off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic sig_ok_reg, sig_ok_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] action_reg, action_next;
    logic [7:0] wdata_reg [0:7];
    logic [7:0] wdata_next [0:7];
    logic [2:0] idx_reg, idx_next;
    logic hob_reg, hob_next;
    logic busy_reg, busy_next;
    logic [3:0] ret_idx_reg, ret_idx_next;
    logic pend_reg, pend_next;
    logic [11:0] ret_sel;
    logic tf_req_reg, tf_req_next;
    logic tf_write_reg, tf_write_next;
    logic tf_hob_reg, tf_hob_next;
    logic [2:0] tf_sel_reg, tf_sel_next;
    logic [7:0] tf_wdata_reg, tf_wdata_next;
    logic data_start_reg, data_start_next;
    logic data_halt_reg, data_halt_next;
    logic rd_valid_reg, rd_valid_next;
    logic [7:0] rd_byte_reg, rd_byte_next;
    logic other_reg, other_next;
    logic done_reg, done_next;
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [7:0] mem_rdata;
    logic [7:0] dh_byte;
    logic need_access;

    tf_return_mem #(
        .WIDTH(8),
        .DEPTH(RETURN_LEN)
    ) u_ret_mem (
        .clk_in(clk_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(tf_rdata_in),
        .raddr_in(ret_idx_reg),
        .rdata_out(mem_rdata)
    );

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sig_ok_next = sig_ok_reg;
        mask_next = mask_reg;
        action_next = action_reg;
        wdata_next = wdata_reg;
        idx_next = idx_reg;
        hob_next = hob_reg;
        ret_idx_next = ret_idx_reg;
        pend_next = 1'b0;
        ret_sel = {mask_reg[7], mask_reg[5:2], mask_reg[5:2], mask_reg[1], mask_reg[6], mask_reg[0]};
        tf_req_next = tf_req_reg;
        tf_write_next = tf_write_reg;
        tf_hob_next = tf_hob_reg;
        tf_sel_next = tf_sel_reg;
        tf_wdata_next = tf_wdata_reg;
        data_start_next = 1'b0;
        data_halt_next = 1'b0;
        rd_valid_next = 1'b0;
        rd_byte_next = BYTE_RESET;
        other_next = 1'b0;
        done_next = 1'b0;
        mem_we = 1'b0;
        mem_waddr = ret_off(idx_reg, hob_reg);
        // Device bit source chosen per command
        dh_byte = wdata_reg[TF_DEVHEAD];
        dh_byte[ATA_DEV] = action_reg[ACT_DEV_SRC] ? wdata_reg[TF_DEVHEAD][CFG_DEV]
                                                  : config_dev_byte_in[CFG_DEV];
        // Alt status never written
        need_access = mask_reg[idx_reg] && (action_reg[ACT_READ_ONLY] ||
                      (idx_reg != TF_ALT && idx_reg != TF_DEVHEAD));
        case (state_reg)
            ST_IDLE: begin
                if (cb_valid_in) begin
                    // Sixteen bytes make one block
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == BYTE_SIG) begin
                        sig_ok_next = (cb_byte_in == vendor_cmd_signature_in);
                    end else if (cnt_reg == BYTE_SUB) begin
                        sig_ok_next = sig_ok_reg && (cb_byte_in == SUBCMD_PASSTHRU);
                    end else if (cnt_reg == BYTE_MASK) begin
                        mask_next = cb_byte_in;
                    end else if (cnt_reg == BYTE_ACTION) begin
                        action_next = cb_byte_in;
                    end else if (cnt_reg >= BYTE_WDATA && cnt_reg <= BYTE_WDATA_END) begin
                        wdata_next[3'(cnt_reg - BYTE_WDATA)] = cb_byte_in;
                    end
                    if (cnt_reg == BYTE_LAST) begin
                        state_next = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                idx_next = TF_ALT;
                hob_next = 1'b1;
                ret_idx_next = 4'h0;
                tf_write_next = 1'b0;
                tf_hob_next = 1'b0;
                tf_sel_next = TF_ALT;
                if (!sig_ok_reg) begin
                    // Foreign block handed back
                    other_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    // Wait for busy clear first
                    tf_req_next = !action_reg[ACT_SKIP_POLL];
                    state_next = ST_POLL;
                end
            end
            ST_POLL: begin
                if (tf_ack_in && tf_rdata_in[ATA_BSY]) begin
                    tf_req_next = 1'b1;
                end else if (!tf_req_reg || tf_ack_in) begin
                    tf_req_next = 1'b0;
                    state_next = (action_reg[ACT_READ_ONLY] || action_reg[ACT_SEL_AFTER])
                                 ? ST_REGS : ST_SELECT;
                end
            end
            ST_SELECT: begin
                // Drive select before or after command writes
                if (!tf_req_reg) begin
                    tf_req_next = 1'b1;
                    tf_write_next = 1'b1;
                    tf_hob_next = 1'b0;
                    tf_sel_next = TF_DEVHEAD;
                    tf_wdata_next = dh_byte;
                end else if (tf_ack_in) begin
                    tf_req_next = 1'b0;
                    state_next = action_reg[ACT_SEL_AFTER] ? ST_DATA : ST_REGS;
                    data_start_next = action_reg[ACT_SEL_AFTER];
                end
            end
            ST_REGS: begin
                // Ascending walk over mask bits
                if (!tf_req_reg && need_access) begin
                    tf_req_next = 1'b1;
                    tf_write_next = !action_reg[ACT_READ_ONLY];
                    // Only the LBA group has a high half
                    tf_hob_next = hob_reg && action_reg[ACT_READ_ONLY] &&
                                  idx_reg >= TF_COUNT && idx_reg <= TF_HIGH;
                    tf_sel_next = idx_reg;
                    tf_wdata_next = wdata_reg[idx_reg];
                end else if (!tf_req_reg || tf_ack_in) begin
                    tf_req_next = 1'b0;
                    mem_we = tf_req_reg && !tf_write_reg;
                    // LBA group read once high, once low
                    if (tf_req_reg && tf_hob_reg) begin
                        hob_next = 1'b0;
                    end else begin
                        hob_next = 1'b1;
                        idx_next = idx_reg + 3'h1;
                        if (idx_reg == TF_CMD) begin
                            if (action_reg[ACT_READ_ONLY]) begin
                                state_next = ST_RETURN;
                            end else if (action_reg[ACT_SEL_AFTER]) begin
                                state_next = ST_SELECT;
                            end else begin
                                state_next = ST_DATA;
                                data_start_next = 1'b1;
                            end
                        end
                    end
                end
            end
            ST_DATA: begin
                if (data_done_in) begin
                    state_next = ST_DONE;
                end else if (drive_error && !action_reg[ACT_DRV_ERR]) begin
                    data_halt_next = 1'b1;
                    state_next = ST_DONE;
                end else if (phase_error_in && !action_reg[ACT_PHASE_ERR]) begin
                    data_halt_next = 1'b1;
                    state_next = ST_DONE;
                end
            end
            ST_RETURN: begin
                // Always twelve bytes, zero where unselected
                if (ret_idx_reg < 4'(RETURN_LEN)) begin
                    pend_next = 1'b1;
                    ret_idx_next = ret_idx_reg + 4'h1;
                end else if (!pend_reg) begin
                    state_next = ST_DONE;
                end
                if (pend_reg) begin
                    rd_valid_next = 1'b1;
                    rd_byte_next = ret_sel[ret_idx_reg - 4'h1] ? mem_rdata : BYTE_RESET;
                end
            end
            ST_DONE: begin
                done_next = 1'b1;
                cnt_next = 4'h0;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next != ST_IDLE) || (cnt_next != 4'h0);
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            sig_ok_reg <= 1'b0;
            mask_reg <= BYTE_RESET;
            action_reg <= BYTE_RESET;
            for (int i = 0; i < 8; i++) begin
                wdata_reg[i] <= BYTE_RESET;
            end
            idx_reg <= TF_ALT;
            hob_reg <= 1'b1;
            busy_reg <= 1'b0;
            ret_idx_reg <= 4'h0;
            pend_reg <= 1'b0;
            tf_req_reg <= 1'b0;
            tf_write_reg <= 1'b0;
            tf_hob_reg <= 1'b0;
            tf_sel_reg <= TF_ALT;
            tf_wdata_reg <= BYTE_RESET;
            data_start_reg <= 1'b0;
            data_halt_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_byte_reg <= BYTE_RESET;
            other_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sig_ok_reg <= sig_ok_next;
            mask_reg <= mask_next;
            action_reg <= action_next;
            wdata_reg <= wdata_next;
            idx_reg <= idx_next;
            hob_reg <= hob_next;
            busy_reg <= busy_next;
            ret_idx_reg <= ret_idx_next;
            pend_reg <= pend_next;
            tf_req_reg <= tf_req_next;
            tf_write_reg <= tf_write_next;
            tf_hob_reg <= tf_hob_next;
            tf_sel_reg <= tf_sel_next;
            tf_wdata_reg <= tf_wdata_next;
            data_start_reg <= data_start_next;
            data_halt_reg <= data_halt_next;
            rd_valid_reg <= rd_valid_next;
            rd_byte_reg <= rd_byte_next;
            other_reg <= other_next;
            done_reg <= done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    assign tf_req_out = tf_req_reg;
    assign tf_write_out = tf_write_reg;
    assign tf_hob_out = tf_hob_reg;
    assign tf_sel_out = tf_sel_reg;
    assign tf_wdata_out = tf_wdata_reg;
    assign data_start_out = data_start_reg;
    // Held from the stored action byte
    assign ultra_dma_enable_out = action_reg[ACT_UDMA];
    assign identify_data_flag_out = action_reg[ACT_IDENTIFY];
    assign data_halt_out = data_halt_reg;
    assign rd_valid_out = rd_valid_reg;
    assign rd_byte_out = rd_byte_reg;
    assign other_cmd_out = other_reg;
    assign cmd_done_out = done_reg;
    assign busy_out = busy_reg;
endmodule
`default_nettype wire

// *** hw/ata_passthru_pkg.sv ***
// Constants shared by the pass-through command block decoder.
// Assumes byte-wide command and taskfile paths on one clock.
package ata_passthru_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command block layout
    localparam int BLOCK_LEN = 16;
    localparam int RETURN_LEN = 12;
    localparam logic [3:0] BYTE_LAST = 4'hF;
    localparam logic [3:0] BYTE_SIG = 4'h0;
    localparam logic [3:0] BYTE_SUB = 4'h1;
    localparam logic [3:0] BYTE_MASK = 4'h2;
    localparam logic [3:0] BYTE_ACTION = 4'h3;
    localparam logic [3:0] BYTE_WDATA = 4'h5;
    localparam logic [3:0] BYTE_WDATA_END = 4'hC;
    localparam logic [7:0] SUBCMD_PASSTHRU = 8'h25;

    ////////////////////////////////////////////////////////////////////////
    // Action byte bit positions
    localparam int ACT_IDENTIFY = 7;
    localparam int ACT_UDMA = 6;
    localparam int ACT_DEV_SRC = 5;
    localparam int ACT_DRV_ERR = 4;
    localparam int ACT_PHASE_ERR = 3;
    localparam int ACT_SKIP_POLL = 2;
    localparam int ACT_SEL_AFTER = 1;
    localparam int ACT_READ_ONLY = 0;

    ////////////////////////////////////////////////////////////////////////
    // Taskfile selects = mask bit
    localparam logic [2:0] TF_ALT = 3'h0;
    localparam logic [2:0] TF_FEAT = 3'h1;
    localparam logic [2:0] TF_COUNT = 3'h2;
    localparam logic [2:0] TF_HIGH = 3'h5;
    localparam logic [2:0] TF_DEVHEAD = 3'h6;
    localparam logic [2:0] TF_CMD = 3'h7;
    localparam int ATA_BSY = 7;
    localparam int ATA_DEV = 4;
    localparam int CFG_DEV = 5;

    ////////////////////////////////////////////////////////////////////////
    // Offsets of the returned taskfile bytes
    localparam logic [3:0] RET_ALT = 4'h0;
    localparam logic [3:0] RET_DEV = 4'h1;
    localparam logic [3:0] RET_ERR = 4'h2;
    localparam logic [3:0] RET_HOB_BASE = 4'h3;
    localparam logic [3:0] RET_LOB_BASE = 4'h7;
    localparam logic [3:0] RET_STAT = 4'hB;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CHECK, ST_POLL, ST_SELECT, ST_REGS, ST_DATA, ST_RETURN, ST_DONE
    } state_t;

endpackage

// *** hw/pin_sync3.sv ***
// Three-stage synchroniser for one asynchronous input pin.
// Output changes only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Pin and result
    input wire logic d_in,
    output logic q_out
);
    logic s1_reg, s2_reg, s3_reg, q_reg;
    logic q_next;

    always_comb begin
        q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule
`default_nettype wire

// *** hw/tf_return_mem.sv ***
// Small byte store for taskfile values read back from the drive.
// Read data is registered: valid one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module tf_return_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 12
) (
    // Clock
    input wire logic clk_in,
    // Write port
    input wire logic we_in,
    input wire logic [$clog2(DEPTH)-1:0] waddr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] raddr_in,
    output logic [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [WIDTH-1:0] rdata_reg;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("tf_return_mem: DEPTH must be at least 2");
    end

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_reg <= mem[raddr_in];
    end

    assign rdata_out = rdata_reg;
endmodule
`default_nettype wire

// *** verification/ata_passthru_monitor.sv ***
// Port checker for the pass-through decoder.
// Assumes it is bound to the decoder and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ata_passthru_monitor (
    // Clock, reset, command bytes
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cb_valid_in,
    input wire logic [7:0] cb_byte_in,
    input wire logic busy_out,
    // Taskfile and results
    input wire logic tf_req_out,
    input wire logic tf_write_out,
    input wire logic [2:0] tf_sel_out,
    input wire logic tf_ack_in,
    input wire logic data_start_out,
    input wire logic ultra_dma_enable_out,
    input wire logic identify_data_flag_out,
    input wire logic data_halt_out,
    input wire logic rd_valid_out,
    input wire logic other_cmd_out,
    input wire logic cmd_done_out
);
    logic [3:0] idx_reg, idx_next;
    logic [7:0] act_reg, act_next;
    logic [4:0] run_reg, run_next;
    logic fresh_reg, fresh_next;
    ////////////////////////////////////////////////////////////////////////
    // Shadow byte count, like the block
    always_comb begin
        idx_next = idx_reg;
        act_next = act_reg;
        fresh_next = fresh_reg && !tf_req_out && !other_cmd_out;
        run_next = rd_valid_out ? run_reg + 5'h01 : 5'h00;
        if (cb_valid_in && (idx_reg != 4'h0 || !busy_out)) begin
            idx_next = idx_reg + 4'h1;
            if (idx_reg == 4'h3) act_next = cb_byte_in;
            if (idx_reg == 4'hF) fresh_next = 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idx_reg <= 4'h0;
            act_reg <= 8'h00;
            run_reg <= 5'h00;
            fresh_reg <= 1'b0;
        end else begin
            idx_reg <= idx_next;
            act_reg <= act_next;
            run_reg <= run_next;
            fresh_reg <= fresh_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb_mon @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_other_pulse:
        assert property (other_cmd_out |-> !tf_req_out ##1 !other_cmd_out)
        else $error("foreign block answer wrong");
    a_req_hold:
        assert property (tf_req_out && !tf_ack_in |=> tf_req_out && $stable(tf_sel_out)
            && $stable(tf_write_out)) else $error("taskfile request not held");
    a_alt_nowrite:
        assert property (tf_req_out && tf_write_out |-> tf_sel_out != 3'h0)
        else $error("alternate status written");
    a_return_twelve:
        assert property ($fell(rd_valid_out) |-> run_reg == 5'h0C)
        else $error("return length not twelve");
    a_poll_first:
        assert property (fresh_reg && tf_req_out && !act_reg[2] |-> tf_sel_out == 3'h0
            && !tf_write_out) else $error("busy poll missing");
    a_dma_flag:
        assert property (data_start_out |-> ultra_dma_enable_out == act_reg[6])
        else $error("transfer mode flag wrong");
    a_ident_flag:
        assert property (data_start_out |-> identify_data_flag_out == act_reg[7])
        else $error("identify flag wrong");
    a_override_keep:
        assert property (act_reg[4] && act_reg[3] && busy_out |-> !data_halt_out)
        else $error("halt despite override");
    a_halt_done:
        assert property (data_halt_out |=> cmd_done_out) else $error("halt not finished");
endmodule
bind ata_passthru_decoder ata_passthru_monitor mon_u (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .cb_valid_in(cb_valid_in), .cb_byte_in(cb_byte_in),
    .busy_out(busy_out), .tf_req_out(tf_req_out), .tf_write_out(tf_write_out),
    .tf_sel_out(tf_sel_out), .tf_ack_in(tf_ack_in), .data_start_out(data_start_out),
    .ultra_dma_enable_out(ultra_dma_enable_out), .data_halt_out(data_halt_out),
    .identify_data_flag_out(identify_data_flag_out), .rd_valid_out(rd_valid_out),
    .other_cmd_out(other_cmd_out), .cmd_done_out(cmd_done_out));
`default_nettype wire

// *** verification/tf_drive_model.sv ***
// Drive taskfile model answering the decoder's register accesses.
// Assumes one clock; bench sets dly and busy_left.
`timescale 1ns/1ps
`default_nettype none
module tf_drive_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Taskfile port
    input wire logic tf_req_in,
    input wire logic tf_write_in,
    input wire logic tf_hob_in,
    input wire logic [2:0] tf_sel_in,
    input wire logic [7:0] tf_wdata_in,
    output logic tf_ack_out,
    output logic [7:0] tf_rdata_out
);
    int dly = 0;
    int busy_left = 0;
    int wait_cnt = 0;
    logic [12:0] log_q[$];
    // Data toggles off ack: stale samples fail
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tf_ack_out <= 1'b0;
            tf_rdata_out <= 8'h5A;
            wait_cnt = 0;
        end else if (tf_ack_out) begin
            tf_ack_out <= 1'b0;
            tf_rdata_out <= ~tf_rdata_out;
            log_q.push_back({tf_write_in, tf_hob_in, tf_sel_in, tf_wdata_in});
        end else if (tf_req_in && wait_cnt >= dly) begin
            wait_cnt = 0;
            tf_ack_out <= 1'b1;
            tf_rdata_out <= {1'b0, tf_hob_in, 3'h4, tf_sel_in};
            if (tf_sel_in == 3'h0 && busy_left > 0) begin
                tf_rdata_out <= 8'h80;
                busy_left--;
            end
        end else begin
            if (tf_req_in) wait_cnt++;
            tf_rdata_out <= ~tf_rdata_out;
        end
    end
endmodule
`default_nettype wire

// *** verification/ata_passthru_decoder_bench.sv ***
// Self-checking bench for the pass-through decoder.
// Assumes all other files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module ata_passthru_decoder_bench;
    import ata_passthru_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cb_valid_in = 1'b0;
    logic [7:0] cb_byte_in = 8'h00;
    logic [7:0] cfg_dev = 8'h00;
    logic [2:0] ev = 3'h0;
    logic tf_req, tf_write, tf_hob, tf_ack, ds, udma, ident, halt, rd_valid, other, done;
    logic [2:0] tf_sel;
    logic [7:0] tf_wdata, tf_rdata, rd_byte;
    logic [7:0] ret_q[$];
    int fail_count = 0;
    int num_checks = 0;
    int ds_cnt, done_cnt, other_cnt, halt_cnt;
    ata_passthru_decoder dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .cb_valid_in(cb_valid_in), .cb_byte_in(cb_byte_in), .vendor_cmd_signature_in(8'hC5),
        .config_dev_byte_in(cfg_dev), .tf_req_out(tf_req), .tf_write_out(tf_write),
        .tf_hob_out(tf_hob), .tf_sel_out(tf_sel), .tf_wdata_out(tf_wdata), .tf_ack_in(tf_ack),
        .tf_rdata_in(tf_rdata), .data_start_out(ds), .ultra_dma_enable_out(udma),
        .identify_data_flag_out(ident), .data_halt_out(halt), .data_done_in(ev[0]),
        .phase_error_in(ev[1]), .drive_error_pin_in(ev[2]), .rd_valid_out(rd_valid),
        .rd_byte_out(rd_byte), .other_cmd_out(other), .cmd_done_out(done), .busy_out());
    tf_drive_model model_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .tf_req_in(tf_req),
        .tf_write_in(tf_write), .tf_hob_in(tf_hob), .tf_sel_in(tf_sel),
        .tf_wdata_in(tf_wdata), .tf_ack_out(tf_ack), .tf_rdata_out(tf_rdata));
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (rd_valid === 1'b1) ret_q.push_back(rd_byte);
        ds_cnt += (ds === 1'b1);
        done_cnt += (done === 1'b1);
        other_cnt += (other === 1'b1);
        halt_cnt += (halt === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic send_block(input logic [7:0] sig, sub, mask, act, dh);
        logic [7:0] b[16] = '{default: 8'h00};
        b[0] = sig;
        b[1] = sub;
        b[2] = mask;
        b[3] = act;
        for (int i = 0; i < 8; i++) b[5 + i] = 8'h40 + 8'(i);
        b[11] = dh;
        model_u.log_q.delete();
        ret_q.delete();
        {ds_cnt, done_cnt, other_cnt, halt_cnt} = '0;
        for (int i = 0; i < BLOCK_LEN; i++) begin
            @(posedge clk_in);
            cb_valid_in <= 1'b1;
            cb_byte_in <= b[i];
        end
        @(posedge clk_in);
        cb_valid_in <= 1'b0;
    endtask
    task automatic wait_for(ref int c);
        for (int n = 0; n < 400 && c == 0; n++) @(posedge clk_in);
        #1;
        `CHK(c > 0, 1'b1)
    endtask
    task automatic pulse(input logic [2:0] m, input int n);
        @(posedge clk_in);
        ev <= m;
        repeat (n) @(posedge clk_in);
        ev <= 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reject(input logic [7:0] sig, sub);
        send_block(sig, sub, 8'hFF, 8'h04, 8'h00);
        wait_for(other_cnt);
        `CHK(model_u.log_q.size(), 0)
    endtask
    task automatic t_read_only();
        logic [4:0] exp_log[7] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h0A, 5'h02, 5'h07};
        logic [7:0] exp_ret[12] = '{8'h20, 0, 0, 8'h62, 0, 0, 0, 8'h22, 0, 0, 0, 8'h27};
        model_u.dly = 3;
        model_u.busy_left = 2;
        send_block(8'hC5, SUBCMD_PASSTHRU, 8'h85, 8'h01, 8'h00);
        wait_for(done_cnt);
        `CHK(model_u.log_q.size(), 7)
        foreach (exp_log[i]) `CHK(model_u.log_q[i][12:8], exp_log[i])
        `CHK(ret_q.size(), RETURN_LEN)
        foreach (exp_ret[i]) `CHK(ret_q[i], exp_ret[i])
    endtask
    task automatic t_command(input logic [7:0] mask, act, dh, cfg);
        logic [2:0] ord[$];
        logic [12:0] e;
        for (int b = 1; b < 8; b++) if (b != 6 && mask[b]) ord.push_back(3'(b));
        if (act[ACT_SEL_AFTER]) ord.push_back(TF_DEVHEAD);
        else ord.push_front(TF_DEVHEAD);
        model_u.dly = 0;
        cfg_dev <= cfg;
        send_block(8'hC5, SUBCMD_PASSTHRU, mask, act, dh);
        wait_for(ds_cnt);
        `CHK(udma, act[ACT_UDMA])
        `CHK(ident, act[ACT_IDENTIFY])
        if (act[ACT_DRV_ERR]) pulse(3'h6, 5);
        pulse(3'h1, 1);
        wait_for(done_cnt);
        `CHK(halt_cnt, 0)
        `CHK(model_u.log_q.size(), ord.size())
        foreach (ord[i]) begin
            e = model_u.log_q[i];
            `CHK({e[12], e[10:8]}, {1'b1, ord[i]})
            if (ord[i] == TF_DEVHEAD) `CHK(e[4], act[ACT_DEV_SRC] ? dh[5] : cfg[5])
            else `CHK(e[7:0], 8'h40 + 8'(ord[i]))
        end
    endtask
    task automatic t_halt(input logic [2:0] m);
        send_block(8'hC5, SUBCMD_PASSTHRU, 8'h80, 8'h04, 8'h00);
        wait_for(ds_cnt);
        pulse(m, 5);
        wait_for(done_cnt);
        `CHK(halt_cnt, 1)
    endtask
    task automatic results();
        if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fail_count++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_reject(8'hC4, SUBCMD_PASSTHRU);
        t_reject(8'hC5, 8'h24);
        t_read_only();
        t_command(8'hFF, 8'h64, 8'h20, 8'h00);
        t_command(8'h82, 8'h9E, 8'h00, 8'h20);
        t_halt(3'h2);
        t_halt(3'h4);
        results();
    end
endmodule
`default_nettype wire
